// ### verilog/auto_xfer_defines.svh
// Constants of the automatic serial buffer transfer engine
`ifndef AUTO_XFER_DEFINES_SVH
`define AUTO_XFER_DEFINES_SVH

`define AX_DATA_W        8
`define AX_PTR_W         4
`define AX_BUF_BASE      16'hFFA0
`define AX_BUF_TOP       16'hFFAF
`define AX_BITS_PER_BYTE 4'h8
`define AX_IVL_MIN_PER   7'h02
`define AX_PTR_RST       4'h0
`define AX_BYTE_RST      8'h00

`endif

// ### verilog/auto_xfer_pkg.sv
// Types shared by the automatic serial buffer transfer engine
`include "auto_xfer_defines.svh"

package auto_xfer_pkg;
  typedef logic [`AX_DATA_W-1:0] byte_t;
  typedef logic [`AX_PTR_W-1:0]  ptr_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_FETCH,
    ST_SHIFT,
    ST_STORE,
    ST_GAP
  } xfer_state_e;
endpackage : auto_xfer_pkg

// ### verilog/xfer_buffer_ram.sv
// Sixteen-byte buffer RAM with a CPU port and an engine port
`timescale 1ns/1ns
`default_nettype none
`include "auto_xfer_defines.svh"

module xfer_buffer_ram
  import auto_xfer_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  cpu_we,
  input  wire ptr_t  cpu_addr,
  input  wire byte_t cpu_wdata,
  output byte_t      cpu_rdata,
  input  wire logic  eng_we,
  input  wire ptr_t  eng_addr,
  input  wire byte_t eng_wdata,
  output byte_t      eng_rdata
);

  byte_t mem [0:(1<<`AX_PTR_W)-1];

  // Engine write placed last so it wins a same-address clash
  always_ff @(posedge sys_clk) begin
    if (cpu_we) begin
      mem[cpu_addr] <= cpu_wdata;
    end
    if (eng_we) begin
      mem[eng_addr] <= eng_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    cpu_rdata <= mem[cpu_addr];
    eng_rdata <= mem[eng_addr];
  end

endmodule : xfer_buffer_ram

`default_nettype wire

// ### verilog/auto_serial_buffer_xfer.sv
// Automatic transmit/receive engine between buffer RAM and a 3-wire serial link
`timescale 1ns/1ns
`default_nettype none
`include "auto_xfer_defines.svh"

module auto_serial_buffer_xfer
  import auto_xfer_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       serial_enable_bit,
  input  wire logic       auto_mode_enable_bit,
  input  wire logic       receive_enable_bit,
  input  wire logic       reload_bit,
  input  wire logic       interval_control_bit,
  input  wire logic [4:0] interval_n,
  input  wire logic       shift_wr,
  input  wire byte_t      shift_wr_data,
  input  wire logic       ptr_wr,
  input  wire ptr_t       ptr_wr_data,
  output ptr_t            buffer_pointer,
  output logic            transfer_in_progress_flag,
  output logic            serial_irq_request_flag,
  input  wire logic       irq_ack,
  input  wire logic       cpu_ram_we,
  input  wire ptr_t       cpu_ram_addr,
  input  wire byte_t      cpu_ram_wdata,
  output byte_t           cpu_ram_rdata,
  input  wire logic       sck_in,
  input  wire logic       serial_data_in_pin,
  output logic            serial_data_out_pin,
  output logic            si_port_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Interval length in serial clock edges (two edges per period, one edge more when ctrl is set)
  function automatic logic [6:0] interval_edges(input logic ctrl, input logic [4:0] n);
    logic [6:0] per;
    per = {2'h0, n} + 7'h01;
    if (!ctrl || per < `AX_IVL_MIN_PER) begin
      per = `AX_IVL_MIN_PER;
    end
    interval_edges = ctrl ? ((per << 1) + 7'h01) : (per << 1);
  endfunction : interval_edges

  xfer_state_e state_r;
  ptr_t        ptr_r;
  byte_t       tx_r;
  byte_t       rx_r;
  logic [3:0]  bit_cnt_r;
  logic [6:0]  gap_cnt_r;
  logic        busy_r;
  logic        irq_r;
  logic        sck_m_r;
  logic        sck_s_r;
  logic        sck_d_r;
  logic        si_m_r;
  logic        si_s_r;
  logic        sck_rise;
  logic        sck_fall;
  logic        start;
  logic        last_byte;
  logic        eng_we;
  byte_t       eng_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Link inputs come from another clock; two stages before use
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      si_m_r  <= 1'b0;
      si_s_r  <= 1'b0;
    end else begin
      sck_m_r <= sck_in;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      si_m_r  <= serial_data_in_pin;
      si_s_r  <= si_m_r;
    end
  end

  assign sck_rise = sck_s_r & ~sck_d_r;
  assign sck_fall = ~sck_s_r & sck_d_r;

  // Repeat mode is not supported, so reload set blocks the trigger
  assign start = shift_wr && serial_enable_bit && auto_mode_enable_bit
                 && !reload_bit && !busy_r;
  assign last_byte = (ptr_r == `AX_PTR_RST);
  assign eng_we = (state_r == ST_STORE) && receive_enable_bit;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_r <= ST_FETCH;
        end
        ST_FETCH: begin
          state_r <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (sck_rise && bit_cnt_r == `AX_BITS_PER_BYTE - 4'h1) begin
            state_r <= ST_STORE;
          end
        end
        ST_STORE: begin
          state_r <= last_byte ? ST_IDLE : ST_GAP;
        end
        ST_GAP: begin
          if (gap_cnt_r == 7'h00) begin
            state_r <= ST_LOAD;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Pointer writes from software are ignored mid-block
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ptr_r <= `AX_PTR_RST;
    end else if (state_r == ST_STORE && !last_byte) begin
      ptr_r <= ptr_r - 4'h1;
    end else if (ptr_wr && !busy_r) begin
      ptr_r <= ptr_wr_data;
    end
  end

  // Idle value of the shifter is zero, so the output rests low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_r      <= `AX_BYTE_RST;
      rx_r      <= `AX_BYTE_RST;
      bit_cnt_r <= 4'h0;
    end else if (state_r == ST_FETCH) begin
      tx_r      <= eng_rdata;
      bit_cnt_r <= 4'h0;
    end else if (state_r == ST_SHIFT) begin
      if (sck_rise) begin
        rx_r      <= {rx_r[6:0], si_s_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (sck_fall && bit_cnt_r != 4'h0) begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end else if (state_r == ST_STORE && last_byte) begin
      tx_r <= `AX_BYTE_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_cnt_r <= 7'h00;
    end else if (state_r == ST_STORE) begin
      // Counter starts at the full edge count so exactly that many edges are swallowed
      gap_cnt_r <= interval_edges(interval_control_bit, interval_n);
    end else if (state_r == ST_GAP && (sck_rise || sck_fall) && gap_cnt_r != 7'h00) begin
      gap_cnt_r <= gap_cnt_r - 7'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
    end else if (state_r == ST_STORE && last_byte) begin
      busy_r <= 1'b0;
    end
  end

  // A completion in the acknowledge cycle still sets the flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (state_r == ST_STORE && last_byte) begin
      irq_r <= 1'b1;
    end else if (irq_ack) begin
      irq_r <= 1'b0;
    end
  end

  xfer_buffer_ram u_ram (
    .sys_clk   (sys_clk),
    .cpu_we    (cpu_ram_we),
    .cpu_addr  (cpu_ram_addr),
    .cpu_wdata (cpu_ram_wdata),
    .cpu_rdata (cpu_ram_rdata),
    .eng_we    (eng_we),
    .eng_addr  (ptr_r),
    .eng_wdata (rx_r),
    .eng_rdata (eng_rdata)
  );

  assign buffer_pointer            = ptr_r;
  assign transfer_in_progress_flag = busy_r;
  assign serial_irq_request_flag   = irq_r;
  assign serial_data_out_pin       = tx_r[7];
  assign si_port_mode              = !(busy_r && receive_enable_bit);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_byte_done;
    state_r == ST_STORE && !last_byte;
  endsequence

  sequence s_gap_hold;
    (state_r == ST_GAP)[*4];
  endsequence

  a_trigger_sets_busy: assert property (start |=> busy_r && state_r == ST_LOAD)
    else $error("trigger did not set busy");
  a_trigger_discards: assert property (start |=> tx_r == `AX_BYTE_RST ##1 tx_r == `AX_BYTE_RST)
    else $error("trigger data reached shifter");
  a_idle_out_low: assert property (!busy_r |-> !serial_data_out_pin)
    else $error("data output not low when idle");
  a_irq_at_end: assert property ($rose(irq_r) |-> $fell(busy_r))
    else $error("interrupt flag set mid-block");
  a_end_clears: assert property (state_r == ST_STORE && last_byte |=> !busy_r && state_r == ST_IDLE)
    else $error("busy not cleared at end");
  a_ptr_decrement: assert property (s_byte_done |=> ptr_r == $past(ptr_r) - 4'h1)
    else $error("pointer not decremented");
  a_gap_inserted: assert property (s_byte_done |=> s_gap_hold)
    else $error("interval too short");
  a_rx_gating: assert property (eng_we |-> receive_enable_bit && state_r == ST_STORE)
    else $error("buffer written without receive");
  a_load_from_ram: assert property (state_r == ST_FETCH |=> tx_r == $past(eng_rdata) ##0 state_r == ST_SHIFT)
    else $error("shifter not loaded from buffer");
  a_store_order: assert property (eng_we |=> ptr_r != $past(ptr_r) || $past(last_byte))
    else $error("store not followed by decrement");

endmodule : auto_serial_buffer_xfer

`default_nettype wire

// ### test/serial_peer.sv
// Behavioural serial peer that clocks the link and exchanges bytes, and the testbench
`timescale 1ns/1ns
`default_nettype none
module serial_peer
  import auto_xfer_pkg::*;
(
  input  wire logic       go,
  input  wire logic [4:0] nbytes,
  input  wire logic [6:0] gap_rises,
  input  wire logic       sdo,
  output logic            sck,
  output logic            sdi,
  output logic            done
);
  byte_t  got [0:15];
  byte_t  pat;
  integer b;
  integer i;

  initial begin
    sck  = 1'b0;
    sdi  = 1'b0;
    done = 1'b0;
  end

  // Clock master; keeps clocking through the interval, rests low between blocks
  always @(posedge go) begin
    done = 1'b0;
    #100;
    for (b = 0; b < nbytes; b++) begin
      pat = 8'hC3 + b[7:0];
      for (i = 7; i >= 0; i--) begin
        sdi = pat[i];
        #62 sck = 1'b1;
        got[b][i] = sdo;
        #63 sck = 1'b0;
      end
      if (b < nbytes - 1) begin
        for (i = 0; i < gap_rises; i++) begin
          #62 sck = 1'b1;
          #63 sck = 1'b0;
        end
      end
    end
    sdi  = 1'b0;
    done = 1'b1;
  end
endmodule : serial_peer

////////////////////////////////////////////////////////////////////////////
module testbench
  import auto_xfer_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       serial_en;
  logic       auto_en;
  logic       rx_en;
  logic       reload;
  logic       ivl_ctrl;
  logic [4:0] ivl_n;
  logic       shift_wr;
  byte_t      shift_data;
  logic       ptr_wr;
  ptr_t       ptr_data;
  ptr_t       buffer_pointer;
  logic       busy;
  logic       irq;
  logic       irq_ack;
  logic       ram_we;
  ptr_t       ram_addr;
  byte_t      ram_wdata;
  byte_t      ram_rdata;
  logic       sck;
  logic       sdi;
  logic       sdo;
  logic       si_port_mode;
  logic       go;
  logic [4:0] nbytes;
  logic [6:0] gap_rises;
  logic       done;
  int         miscompares = 0;
  int         tests_run = 0;

  always #5 sys_clk = ~sys_clk;

  auto_serial_buffer_xfer i_dut (
    .sys_clk                   (sys_clk),
    .rst                       (rst),
    .serial_enable_bit         (serial_en),
    .auto_mode_enable_bit      (auto_en),
    .receive_enable_bit        (rx_en),
    .reload_bit                (reload),
    .interval_control_bit      (ivl_ctrl),
    .interval_n                (ivl_n),
    .shift_wr                  (shift_wr),
    .shift_wr_data             (shift_data),
    .ptr_wr                    (ptr_wr),
    .ptr_wr_data               (ptr_data),
    .buffer_pointer            (buffer_pointer),
    .transfer_in_progress_flag (busy),
    .serial_irq_request_flag   (irq),
    .irq_ack                   (irq_ack),
    .cpu_ram_we                (ram_we),
    .cpu_ram_addr              (ram_addr),
    .cpu_ram_wdata             (ram_wdata),
    .cpu_ram_rdata             (ram_rdata),
    .sck_in                    (sck),
    .serial_data_in_pin        (sdi),
    .serial_data_out_pin       (sdo),
    .si_port_mode              (si_port_mode)
  );

  serial_peer i_peer (
    .go        (go),
    .nbytes    (nbytes),
    .gap_rises (gap_rises),
    .sdo       (sdo),
    .sck       (sck),
    .sdi       (sdi),
    .done      (done)
  );

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic ram_write(input ptr_t a, input byte_t d);
    @(posedge sys_clk);
    ram_we    <= 1'b1;
    ram_addr  <= a;
    ram_wdata <= d;
    @(posedge sys_clk);
    ram_we    <= 1'b0;
  endtask : ram_write

  task automatic ram_check(input string name, input ptr_t a, input byte_t exp);
    @(posedge sys_clk);
    ram_addr <= a;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(name, ram_rdata, exp);
  endtask : ram_check

  task automatic load_ptr(input ptr_t p);
    @(posedge sys_clk);
    ptr_wr   <= 1'b1;
    ptr_data <= p;
    @(posedge sys_clk);
    ptr_wr   <= 1'b0;
  endtask : load_ptr

  task automatic trigger(input logic with_peer);
    @(posedge sys_clk);
    shift_wr   <= 1'b1;
    shift_data <= 8'hFF;
    go         <= with_peer;
    @(posedge sys_clk);
    shift_wr   <= 1'b0;
    go         <= 1'b0;
  endtask : trigger

  // Bounded waits; a run-out counts as a mismatch and ends the run
  task automatic wait_done();
    int k;
    for (k = 0; k < 3000 && busy; k++) begin
      @(posedge sys_clk);
    end
    for (k = 0; k < 300 && !done; k++) begin
      @(posedge sys_clk);
    end
    if (busy || !done) begin
      miscompares++;
      report_and_stop();
    end
    @(negedge sys_clk);
  endtask : wait_done

  initial begin
    serial_en  <= 1'b0;
    auto_en    <= 1'b0;
    rx_en      <= 1'b0;
    reload     <= 1'b0;
    ivl_ctrl   <= 1'b0;
    ivl_n      <= 5'h00;
    shift_wr   <= 1'b0;
    shift_data <= 8'h00;
    ptr_wr     <= 1'b0;
    ptr_data   <= 4'h0;
    irq_ack    <= 1'b0;
    ram_we     <= 1'b0;
    ram_addr   <= 4'h0;
    ram_wdata  <= 8'h00;
    go         <= 1'b0;
    nbytes     <= 5'h00;
    gap_rises  <= 7'h00;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("busy after reset", {7'h00, busy}, 8'h00);
    check("pointer after reset", {4'h0, buffer_pointer}, 8'h00);
    // Transmit/receive, three bytes, interval under CPU timing
    ram_write(4'h0, 8'h11);
    ram_write(4'h1, 8'h22);
    ram_write(4'h2, 8'h33);
    load_ptr(4'h2);
    @(negedge sys_clk);
    check("pointer load", {4'h0, buffer_pointer}, 8'h02);
    serial_en <= 1'b1;
    auto_en   <= 1'b1;
    rx_en     <= 1'b1;
    ivl_ctrl  <= 1'b0;
    nbytes    <= 5'h03;
    gap_rises <= 7'h02;
    trigger(1'b1);
    @(negedge sys_clk);
    check("busy after trigger", {7'h00, busy}, 8'h01);
    check("input pin claimed", {7'h00, si_port_mode}, 8'h00);
    wait_done();
    check("irq at end", {7'h00, irq}, 8'h01);
    check("pointer at end", {4'h0, buffer_pointer}, 8'h00);
    check("data out idle", {7'h00, sdo}, 8'h00);
    check("sent byte 0", i_peer.got[0], 8'h33);
    check("sent byte 1", i_peer.got[1], 8'h22);
    check("sent byte 2", i_peer.got[2], 8'h11);
    ram_check("stored byte 2", 4'h2, 8'hC3);
    ram_check("stored byte 1", 4'h1, 8'hC4);
    ram_check("stored byte 0", 4'h0, 8'hC5);
    @(posedge sys_clk);
    irq_ack <= 1'b1;
    @(posedge sys_clk);
    irq_ack <= 1'b0;
    @(negedge sys_clk);
    check("irq after ack", {7'h00, irq}, 8'h00);
    // Transmit-only, two bytes, interval from the field
    ram_write(4'h1, 8'h5A);
    ram_write(4'h0, 8'h96);
    load_ptr(4'h1);
    rx_en     <= 1'b0;
    ivl_ctrl  <= 1'b1;
    ivl_n     <= 5'h03;
    nbytes    <= 5'h02;
    gap_rises <= 7'h04;
    trigger(1'b1);
    load_ptr(4'hF);
    @(negedge sys_clk);
    check("pointer write refused", {4'h0, buffer_pointer}, 8'h01);
    check("input pin free", {7'h00, si_port_mode}, 8'h01);
    wait_done();
    check("busy cleared", {7'h00, busy}, 8'h00);
    check("irq tx only", {7'h00, irq}, 8'h01);
    check("tx only byte 0", i_peer.got[0], 8'h5A);
    check("tx only byte 1", i_peer.got[1], 8'h96);
    ram_check("untouched byte 1", 4'h1, 8'h5A);
    ram_check("untouched byte 0", 4'h0, 8'h96);
    // Trigger without auto mode is refused
    @(posedge sys_clk);
    auto_en <= 1'b0;
    trigger(1'b0);
    @(negedge sys_clk);
    check("no start without auto", {7'h00, busy}, 8'h00);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
